// *** rtl/gpio_ports_top.sv ***
// Port 0, 1 and 5 GPIO logic behind an AXI4-Lite register slave
//
// How it works
// RL1: Each pin has a direction bit; 0 input, 1 driven output.
// RL2: Direction bits also take single-bit set and clear operations.
// RL3: Port 1 bit 5 is input only; its direction bit reads one.
// RL4: Pull-up enable registers are write-only; a set bit connects the pull-up.
// RL5: Port 1 bit 5 has no pull-up; its enable bit stays one.
// RL6: Open-drain control bit 0 selects open-drain for port 1 bit 0.
// RL7: Open-drain pulls low for latched 0, releases pin for latched 1.
// RL8: Software sets the pin to output first and fits an external pull-up.
// RL9: Clearing open-drain restores the behaviour of the direction bit.
// RL10: Software writes open-drain control as a whole byte, never bitwise.
// RL11: Reading a port data register returns the pin levels.
// RL12: Port data takes byte writes and bit set or clear.
// RL13: With external reset selected, port 1 bit 5 data reads one.
// RL14: Outputs drive the latch; inputs float apart from enabled pull-up.
`timescale 1ns/1ps
`include "gpio_regs.svh"
module gpio_ports_top (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ext_reset_sel,
   input wire logic [11:0] i_s_axi_awaddr,
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   output logic [1:0] o_s_axi_bresp,
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   input wire logic [11:0] i_s_axi_araddr,
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   input wire logic [1:0] i_port0_in,
   output logic [1:0] o_port0_out,
   output logic [1:0] o_port0_oe,
   output logic [1:0] o_port0_pullup,
   input wire logic [7:0] i_port1_in,
   output logic [7:0] o_port1_out,
   output logic [7:0] o_port1_oe,
   output logic [7:0] o_port1_pullup,
   input wire logic [7:0] i_port5_in,
   output logic [7:0] o_port5_out,
   output logic [7:0] o_port5_oe,
   output logic [7:0] o_port5_pullup
);
   localparam logic [7:0] RST_BIT = 8'h01 << `GPIO_RESET_PIN_BIT;

   //==================================================================
   // Write channel
   //==================================================================
   logic [9:0] aw_idx_reg;
   logic aw_held_reg;
   logic [7:0] wdata_reg;
   logic w_held_reg;
   logic wr_fire;
   logic [9:0] wr_idx;
   logic [7:0] wr_reg;
   gpio_pkg::gpio_op_t wr_op;
   logic wr_hit;

   // Decode a word address into register index and bit operation
   function automatic gpio_pkg::gpio_op_t op_of(input logic [9:0] idx);
      if (idx[9:8] == 2'(`GPIO_IDX_SET_BASE >> 8))
         op_of = gpio_pkg::GPIO_OP_SET;
      else if (idx[9:8] == 2'(`GPIO_IDX_CLR_BASE >> 8))
         op_of = gpio_pkg::GPIO_OP_CLEAR;
      else
         op_of = gpio_pkg::GPIO_OP_WRITE;
   endfunction

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         aw_held_reg <= 1'b0;
      else if (wr_fire)
         aw_held_reg <= 1'b0;
      else if (i_s_axi_awvalid && o_s_axi_awready)
         aw_held_reg <= 1'b1;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         aw_idx_reg <= '0;
      else if (i_s_axi_awvalid && o_s_axi_awready)
         aw_idx_reg <= i_s_axi_awaddr[11:2];
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         w_held_reg <= 1'b0;
      else if (wr_fire)
         w_held_reg <= 1'b0;
      else if (i_s_axi_wvalid && o_s_axi_wready)
         w_held_reg <= 1'b1;
   end

   // Lane 0 carries the byte; a write without it uses a zero byte
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         wdata_reg <= `GPIO_RESET_BYTE;
      else if (i_s_axi_wvalid && o_s_axi_wready)
         wdata_reg <= i_s_axi_wstrb[0] ? i_s_axi_wdata[7:0] : 8'h00;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_s_axi_awready <= 1'b0;
         o_s_axi_wready <= 1'b0;
      end
      else
      begin
         o_s_axi_awready <= !aw_held_reg && !(i_s_axi_awvalid &&
            o_s_axi_awready) && !o_s_axi_bvalid && !wr_fire;
         o_s_axi_wready <= !w_held_reg && !(i_s_axi_wvalid &&
            o_s_axi_wready) && !o_s_axi_bvalid && !wr_fire;
      end
   end

   assign wr_fire = aw_held_reg && w_held_reg && !o_s_axi_bvalid;
   assign wr_idx = aw_idx_reg;
   assign wr_reg = wr_idx[7:0];
   assign wr_op = op_of(wr_idx);

   always_comb
   begin
      unique case (wr_reg)
         `GPIO_IDX_PORT0_DIRECTION, `GPIO_IDX_PORT1_DIRECTION,
         `GPIO_IDX_PORT5_DIRECTION, `GPIO_IDX_PORT0_PIN_DATA,
         `GPIO_IDX_PORT1_PIN_DATA, `GPIO_IDX_PORT5_PIN_DATA:
            wr_hit = (wr_idx[9:8] != 2'b11);
         `GPIO_IDX_PORT0_PULLUP_ENABLE, `GPIO_IDX_PORT1_PULLUP_ENABLE,
         `GPIO_IDX_PORT5_PULLUP_ENABLE, `GPIO_IDX_OPENDRAIN_CONTROL:
            wr_hit = (wr_idx[9:8] == 2'b00);
         default: wr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_s_axi_bvalid <= 1'b0;
         o_s_axi_bresp <= `GPIO_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         o_s_axi_bvalid <= 1'b1;
         o_s_axi_bresp <= wr_hit ? `GPIO_RESP_OKAY : `GPIO_RESP_SLVERR;
      end
      else if (i_s_axi_bready)
         o_s_axi_bvalid <= 1'b0;
   end

   //==================================================================
   // Register bits
   //==================================================================
   function automatic logic hit(input logic [7:0] idx);
      hit = wr_fire && wr_hit && (wr_reg == idx);
   endfunction

   logic [7:0] dir0, dir1, dir5, lat0, lat1, lat5, pu0, pu1, pu5, odc;

   // Byte, set and clear writes on direction and latch bits; see RL2
   gpio_port_bits #(.MASK(`GPIO_PORT0_MASK)) u_dir0 (
      .i_clk(i_clk), .i_rst(i_rst),
      .i_we(hit(`GPIO_IDX_PORT0_DIRECTION)), .i_op(wr_op),
      .i_wdata(wdata_reg), .o_value(dir0));
   // Input-only pin direction held at one; see RL3
   gpio_port_bits #(.MASK(`GPIO_PORT1_MASK), .FORCE1(RST_BIT)) u_dir1 (
      .i_clk(i_clk), .i_rst(i_rst),
      .i_we(hit(`GPIO_IDX_PORT1_DIRECTION)), .i_op(wr_op),
      .i_wdata(wdata_reg), .o_value(dir1));
   gpio_port_bits u_dir5 (
      .i_clk(i_clk), .i_rst(i_rst),
      .i_we(hit(`GPIO_IDX_PORT5_DIRECTION)), .i_op(wr_op),
      .i_wdata(wdata_reg), .o_value(dir5));
   // Output latches take byte and bit writes; see RL12
   gpio_port_bits #(.MASK(`GPIO_PORT0_MASK)) u_lat0 (
      .i_clk(i_clk), .i_rst(i_rst),
      .i_we(hit(`GPIO_IDX_PORT0_PIN_DATA)), .i_op(wr_op),
      .i_wdata(wdata_reg), .o_value(lat0));
   gpio_port_bits #(.MASK(`GPIO_PORT1_MASK)) u_lat1 (
      .i_clk(i_clk), .i_rst(i_rst),
      .i_we(hit(`GPIO_IDX_PORT1_PIN_DATA)), .i_op(wr_op),
      .i_wdata(wdata_reg), .o_value(lat1));
   gpio_port_bits u_lat5 (
      .i_clk(i_clk), .i_rst(i_rst),
      .i_we(hit(`GPIO_IDX_PORT5_PIN_DATA)), .i_op(wr_op),
      .i_wdata(wdata_reg), .o_value(lat5));
   // Write-only pull-up enables; see RL4
   gpio_port_bits #(.MASK(`GPIO_PORT0_MASK)) u_pu0 (
      .i_clk(i_clk), .i_rst(i_rst),
      .i_we(hit(`GPIO_IDX_PORT0_PULLUP_ENABLE)), .i_op(wr_op),
      .i_wdata(wdata_reg), .o_value(pu0));
   // Reset pin enable bit held at one, never drives a resistor; see RL5
   gpio_port_bits #(.MASK(`GPIO_PORT1_MASK), .FORCE1(RST_BIT)) u_pu1 (
      .i_clk(i_clk), .i_rst(i_rst),
      .i_we(hit(`GPIO_IDX_PORT1_PULLUP_ENABLE)), .i_op(wr_op),
      .i_wdata(wdata_reg), .o_value(pu1));
   gpio_port_bits u_pu5 (
      .i_clk(i_clk), .i_rst(i_rst),
      .i_we(hit(`GPIO_IDX_PORT5_PULLUP_ENABLE)), .i_op(wr_op),
      .i_wdata(wdata_reg), .o_value(pu5));
   // Whole-byte write only, bit 0 meaningful; see RL6 RL10
   gpio_port_bits #(.MASK(8'h01 << `GPIO_OPENDRAIN_BIT)) u_odc (
      .i_clk(i_clk), .i_rst(i_rst),
      .i_we(hit(`GPIO_IDX_OPENDRAIN_CONTROL)), .i_op(wr_op),
      .i_wdata(wdata_reg), .o_value(odc));

   //==================================================================
   // Pins
   //==================================================================
   logic [17:0] pins_sync;
   logic ext_rst_sel;
   logic [7:0] port1_oe_next;

   gpio_pin_sync #(.WIDTH(18)) u_sync (
      .i_clk(i_clk), .i_rst(i_rst),
      .i_async({i_port5_in, i_port1_in, i_port0_in}),
      .o_sync(pins_sync));

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         ext_rst_sel <= 1'b0;
      else
         ext_rst_sel <= i_ext_reset_sel;
   end

   // Open-drain drives only for a latched 0, else direction decides
   always_comb
   begin
      port1_oe_next = dir1 & ~RST_BIT; // see RL1 RL3 RL9
      if (odc[`GPIO_OPENDRAIN_BIT])
         port1_oe_next[`GPIO_OPENDRAIN_PIN] =
            !lat1[`GPIO_OPENDRAIN_PIN]; // see RL7 RL8
   end

   // Drive latch when output, float when input; see RL1 RL14
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_port0_out <= '0;
         o_port0_oe <= '0;
         o_port0_pullup <= '0;
         o_port1_out <= '0;
         o_port1_oe <= '0;
         o_port1_pullup <= '0;
         o_port5_out <= '0;
         o_port5_oe <= '0;
         o_port5_pullup <= '0;
      end
      else
      begin
         o_port0_out <= lat0[1:0];
         o_port0_oe <= dir0[1:0];
         o_port0_pullup <= pu0[1:0] & ~dir0[1:0]; // see RL4 RL14
         o_port1_out <= lat1;
         o_port1_oe <= port1_oe_next;
         o_port1_pullup <= pu1 & ~port1_oe_next & ~RST_BIT; // see RL5
         o_port5_out <= lat5;
         o_port5_oe <= dir5;
         o_port5_pullup <= pu5 & ~dir5;
      end
   end

   //==================================================================
   // Read channel
   //==================================================================
   logic [7:0] rd_byte;
   logic rd_hit;
   logic [9:0] rd_idx;

   assign rd_idx = i_s_axi_araddr[11:2];

   // Data reads give pin levels; pull-up and open-drain read zero
   always_comb
   begin
      rd_byte = 8'h00;
      rd_hit = (rd_idx[9:8] == 2'b00);
      unique case (rd_idx[7:0])
         `GPIO_IDX_PORT0_DIRECTION: rd_byte = dir0;
         `GPIO_IDX_PORT1_DIRECTION: rd_byte = dir1; // see RL3
         `GPIO_IDX_PORT5_DIRECTION: rd_byte = dir5;
         `GPIO_IDX_PORT0_PIN_DATA:
            rd_byte = {6'h00, pins_sync[1:0]}; // see RL11
         `GPIO_IDX_PORT1_PIN_DATA:
            rd_byte = pins_sync[9:2] | (ext_rst_sel ? RST_BIT : 8'h00);
            // see RL11 RL13
         `GPIO_IDX_PORT5_PIN_DATA: rd_byte = pins_sync[17:10];
         `GPIO_IDX_PORT0_PULLUP_ENABLE, `GPIO_IDX_PORT1_PULLUP_ENABLE,
         `GPIO_IDX_PORT5_PULLUP_ENABLE, `GPIO_IDX_OPENDRAIN_CONTROL:
            rd_byte = 8'h00; // see RL4
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_s_axi_arready <= 1'b0;
         o_s_axi_rvalid <= 1'b0;
         o_s_axi_rdata <= '0;
         o_s_axi_rresp <= `GPIO_RESP_OKAY;
      end
      else if (i_s_axi_arvalid && o_s_axi_arready)
      begin
         o_s_axi_arready <= 1'b0;
         o_s_axi_rvalid <= 1'b1;
         o_s_axi_rdata <= {24'h000000, rd_byte};
         o_s_axi_rresp <= rd_hit ? `GPIO_RESP_OKAY : `GPIO_RESP_SLVERR;
      end
      else if (o_s_axi_rvalid)
      begin
         if (i_s_axi_rready)
            o_s_axi_rvalid <= 1'b0;
      end
      else
         o_s_axi_arready <= 1'b1;
   end
endmodule

// *** rtl/gpio_regs.svh ***
// Register offsets, field positions and reset values of the port block
`ifndef GPIO_REGS_SVH
`define GPIO_REGS_SVH

// Printed offsets are not multiples of four: they are register indexes
`define GPIO_IDX_PORT1_DIRECTION 8'h61
`define GPIO_IDX_PORT0_DIRECTION 8'hb8
`define GPIO_IDX_PORT5_DIRECTION 8'hc5
`define GPIO_IDX_PORT0_PIN_DATA 8'hd0
`define GPIO_IDX_PORT1_PIN_DATA 8'hd1
`define GPIO_IDX_PORT5_PIN_DATA 8'hd5
`define GPIO_IDX_PORT0_PULLUP_ENABLE 8'he0
`define GPIO_IDX_PORT1_PULLUP_ENABLE 8'he1
`define GPIO_IDX_PORT5_PULLUP_ENABLE 8'he5
`define GPIO_IDX_OPENDRAIN_CONTROL 8'he9
// Bit set and bit clear windows: index plus these bases
`define GPIO_IDX_SET_BASE 10'h100
`define GPIO_IDX_CLR_BASE 10'h200

`define GPIO_RESET_BYTE 8'h00
`define GPIO_PORT0_MASK 8'h03
`define GPIO_PORT1_MASK 8'hdf
`define GPIO_RESET_PIN_BIT 5
`define GPIO_OPENDRAIN_BIT 0
`define GPIO_OPENDRAIN_PIN 0
`define GPIO_RESP_OKAY 2'b00
`define GPIO_RESP_SLVERR 2'b10

`endif

// *** rtl/gpio_pkg.sv ***
// Types shared by the port block
package gpio_pkg;
   typedef enum logic [1:0]
   {
      GPIO_OP_WRITE,
      GPIO_OP_SET,
      GPIO_OP_CLEAR
   } gpio_op_t;
endpackage

// *** rtl/gpio_pin_sync.sv ***
// Two-stage synchroniser for the incoming pin levels
`timescale 1ns/1ps
module gpio_pin_sync #(
   parameter int WIDTH = 18
)(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         meta_reg <= '0;
         o_sync <= '0;
      end
      else
      begin
         meta_reg <= i_async;
         o_sync <= meta_reg;
      end
   end
endmodule

// *** rtl/gpio_port_bits.sv ***
// One port worth of latch, direction and pull-up bits with bit operations
`timescale 1ns/1ps
`include "gpio_regs.svh"
module gpio_port_bits #(
   parameter logic [7:0] MASK = 8'hff,
   parameter logic [7:0] FORCE1 = 8'h00
)(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_we,
   input wire gpio_pkg::gpio_op_t i_op,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_value
);
   logic [7:0] value_next;

   always_comb
   begin
      unique case (i_op)
         gpio_pkg::GPIO_OP_SET: value_next = o_value | i_wdata;
         gpio_pkg::GPIO_OP_CLEAR: value_next = o_value & ~i_wdata;
         default: value_next = i_wdata;
      endcase
   end

   // Unimplemented bits read zero, forced bits read one
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         o_value <= (`GPIO_RESET_BYTE & MASK) | FORCE1;
      else if (i_we)
         o_value <= (value_next & MASK) | FORCE1;
   end
endmodule

// *** verif/gpio_ports_sva.sv ***
// Assertions on the bus handshake and pin outputs of the port block
`timescale 1ns/1ps
module gpio_ports_sva (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_s_axi_awvalid,
   input wire logic o_s_axi_awready,
   input wire logic i_s_axi_wvalid,
   input wire logic o_s_axi_wready,
   input wire logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   input wire logic i_s_axi_arvalid,
   input wire logic o_s_axi_arready,
   input wire logic [31:0] o_s_axi_rdata,
   input wire logic o_s_axi_rvalid,
   input wire logic [1:0] o_port0_oe,
   input wire logic [1:0] o_port0_pullup,
   input wire logic [7:0] o_port1_oe,
   input wire logic [7:0] o_port1_pullup,
   input wire logic [7:0] o_port5_oe,
   input wire logic [7:0] o_port5_pullup
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence s_wr_taken;
      i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
   endsequence
   sequence s_rd_taken;
      i_s_axi_arvalid && o_s_axi_arready;
   endsequence
   a_write_answer: assert property (s_wr_taken |-> ##2 o_s_axi_bvalid)
      else $error("write response not on time");
   a_read_answer: assert property (s_rd_taken |=> o_s_axi_rvalid
      && o_s_axi_rdata[31:8] == 24'h0) else $error("read answer wrong");
   a_write_pending: assert property (o_s_axi_bvalid |->
      !o_s_axi_awready && !o_s_axi_wready) else $error("ready during write");
   a_read_pending: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
      else $error("ready during read");
   a_resp_release: assert property (o_s_axi_bvalid && i_s_axi_bready
      |=> !o_s_axi_bvalid) else $error("write response held");
   a_input_only_pin: assert property (!o_port1_oe[5] && !o_port1_pullup[5])
      else $error("input only pin driven or pulled");
   a_pullup_off_drive: assert property ((o_port0_pullup & o_port0_oe) == 2'h0
      && (o_port1_pullup & o_port1_oe) == 8'h0
      && (o_port5_pullup & o_port5_oe) == 8'h0) else $error("pull-up on output");
   a_pins_after_write: assert property ($changed(o_port5_oe)
      |-> $past(o_s_axi_bvalid) || $past(o_s_axi_bvalid, 2)
      || $past(o_s_axi_bvalid, 3)) else $error("direction moved without write");
   a_reset_clear: assert property ($past(i_rst) |-> o_port5_oe == 8'h0
      && o_port1_oe == 8'h0 && !o_s_axi_bvalid && !o_s_axi_rvalid)
      else $error("state left over from reset");
endmodule
bind gpio_ports_top gpio_ports_sva gpio_ports_sva_i (.i_clk, .i_rst,
   .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wvalid, .o_s_axi_wready,
   .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_arvalid, .o_s_axi_arready,
   .o_s_axi_rdata, .o_s_axi_rvalid, .o_port0_oe, .o_port0_pullup,
   .o_port1_oe, .o_port1_pullup, .o_port5_oe, .o_port5_pullup);

// *** verif/gpio_pins_model.sv ***
// Board side of one port: drive, external pull-ups and floating pins
`timescale 1ns/1ps
module gpio_pins_model #(
   parameter int W = 8,
   parameter logic [7:0] EXT_PU = 8'h00
)(
   input wire logic i_clk,
   input wire logic [W-1:0] i_out,
   input wire logic [W-1:0] i_oe,
   input wire logic [W-1:0] i_pullup,
   input wire logic [W-1:0] i_ext_en,
   input wire logic [W-1:0] i_ext_val,
   output logic [W-1:0] o_level
);
   logic tog_reg = 1'h0;
   always_ff @(posedge i_clk)
      tog_reg <= !tog_reg;
   always_comb
   begin
      for (int b = 0; b < W; b++)
      begin
         if (i_oe[b])
            o_level[b] = i_out[b];
         else if (i_ext_en[b])
            o_level[b] = i_ext_val[b];
         else if (i_pullup[b] || EXT_PU[b])
            o_level[b] = 1'h1;
         else
            o_level[b] = tog_reg ^ b[0];
      end
   end
endmodule

// *** verif/test_gpio_ports_dir_pullup_od.sv ***
// Self-checking bench of the port block
`timescale 1ns/1ps
module test_gpio_ports_dir_pullup_od;
   typedef struct packed
   {
      logic [9:0] wi;
      logic [7:0] wd;
      logic [1:0] wr;
      logic [9:0] ri;
      logic [7:0] rd;
      logic [1:0] rr;
   } gpio_row_t;
   logic i_clk = 1'h0, i_rst, i_ext_reset_sel;
   logic [11:0] i_s_axi_awaddr, i_s_axi_araddr;
   logic [31:0] i_s_axi_wdata, o_s_axi_rdata;
   logic i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid;
   logic i_s_axi_rready, o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid;
   logic o_s_axi_arready, o_s_axi_rvalid;
   logic [1:0] o_s_axi_bresp, o_s_axi_rresp, rsp;
   logic [1:0] i_port0_in, o_port0_out, o_port0_oe, o_port0_pullup;
   logic [7:0] i_port1_in, o_port1_out, o_port1_oe, o_port1_pullup;
   logic [7:0] i_port5_in, o_port5_out, o_port5_oe, o_port5_pullup;
   logic [7:0] e1_en, e1_val, e5_en, e5_val;
   logic [31:0] dat;
   int num_errors = 0, total_checks = 0;
   gpio_row_t rows [9] = '{
      '{10'h0b8, 8'hff, 2'h0, 10'h0b8, 8'h03, 2'h0},
      '{10'h061, 8'h00, 2'h0, 10'h061, 8'h20, 2'h0},
      '{10'h061, 8'hff, 2'h0, 10'h061, 8'hff, 2'h0},
      '{10'h0c5, 8'ha5, 2'h0, 10'h0c5, 8'ha5, 2'h0},
      '{10'h1c5, 8'h10, 2'h0, 10'h0c5, 8'hb5, 2'h0},
      '{10'h2c5, 8'h81, 2'h0, 10'h0c5, 8'h34, 2'h0},
      '{10'h0e0, 8'h03, 2'h0, 10'h0e0, 8'h00, 2'h0},
      '{10'h1e0, 8'h01, 2'h2, 10'h0e9, 8'h00, 2'h0},
      '{10'h010, 8'h55, 2'h2, 10'h010, 8'h00, 2'h2}};
   always #5 i_clk = ~i_clk;
   gpio_ports_top gpio_ports_top_i (.i_clk, .i_rst, .i_ext_reset_sel,
      .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wdata,
      .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid, .o_s_axi_wready,
      .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr,
      .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp,
      .o_s_axi_rvalid, .i_s_axi_rready, .i_port0_in, .o_port0_out,
      .o_port0_oe, .o_port0_pullup, .i_port1_in, .o_port1_out, .o_port1_oe,
      .o_port1_pullup, .i_port5_in, .o_port5_out, .o_port5_oe,
      .o_port5_pullup);
   gpio_pins_model #(.W(2)) gpio_pins_model_i0 (.i_clk, .i_out(o_port0_out),
      .i_oe(o_port0_oe), .i_pullup(o_port0_pullup), .i_ext_en(2'h0),
      .i_ext_val(2'h0), .o_level(i_port0_in));
   gpio_pins_model #(.EXT_PU(8'h01)) gpio_pins_model_i1 (.i_clk,
      .i_out(o_port1_out), .i_oe(o_port1_oe), .i_pullup(o_port1_pullup),
      .i_ext_en(e1_en), .i_ext_val(e1_val), .o_level(i_port1_in));
   gpio_pins_model gpio_pins_model_i (.i_clk, .i_out(o_port5_out),
      .i_oe(o_port5_oe), .i_pullup(o_port5_pullup), .i_ext_en(e5_en),
      .i_ext_val(e5_val), .o_level(i_port5_in));
   task automatic check(input string nm, input logic [31:0] s, e);
      total_checks++;
      if (s !== e)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [9:0] idx, input logic [7:0] d,
      output logic [1:0] r);
      logic done;
      done = 1'h0;
      @(posedge i_clk);
      i_s_axi_awaddr <= {idx, 2'h0};
      i_s_axi_wdata <= {24'h0, d};
      i_s_axi_awvalid <= 1'h1;
      i_s_axi_wvalid <= 1'h1;
      i_s_axi_bready <= 1'h1;
      while (!done)
      begin
         @(posedge i_clk);
         if (o_s_axi_awready === 1'h1)
            i_s_axi_awvalid <= 1'h0;
         if (o_s_axi_wready === 1'h1)
            i_s_axi_wvalid <= 1'h0;
         if (o_s_axi_bvalid === 1'h1)
         begin
            r = o_s_axi_bresp;
            i_s_axi_bready <= 1'h0;
            done = 1'h1;
         end
      end
   endtask
   task automatic rd(input logic [9:0] idx, output logic [31:0] d,
      output logic [1:0] r);
      logic done;
      done = 1'h0;
      @(posedge i_clk);
      i_s_axi_araddr <= {idx, 2'h0};
      i_s_axi_arvalid <= 1'h1;
      i_s_axi_rready <= 1'h1;
      while (!done)
      begin
         @(posedge i_clk);
         if (o_s_axi_arready === 1'h1)
            i_s_axi_arvalid <= 1'h0;
         if (o_s_axi_rvalid === 1'h1)
         begin
            d = o_s_axi_rdata;
            r = o_s_axi_rresp;
            i_s_axi_rready <= 1'h0;
            done = 1'h1;
         end
      end
   endtask
   task automatic rchk(input logic [9:0] idx, input logic [7:0] e);
      rd(idx, dat, rsp);
      check("read", dat, {24'h0, e});
   endtask
   task automatic st();
      repeat (8) @(posedge i_clk);
   endtask
   task report_and_stop();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      #100000;
      num_errors++;
      report_and_stop();
   end
   // ===========================================================
   // Scenarios
   initial
   begin
      i_rst <= 1'h1;
      i_ext_reset_sel <= 1'h0;
      {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} <= 3'h0;
      {i_s_axi_arvalid, i_s_axi_rready} <= 2'h0;
      {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata} <= 56'h0;
      {e1_en, e1_val, e5_en, e5_val} <= 32'h0;
      repeat (4) @(posedge i_clk);
      i_rst <= 1'h0;
      for (int k = 0; k < 9; k++)
      begin
         wr(rows[k].wi, rows[k].wd, rsp);
         check("wresp", rsp, rows[k].wr);
         rd(rows[k].ri, dat, rsp);
         check("rresp", rsp, rows[k].rr);
         if (rows[k].rr == 2'h0)
            check("rdata", dat, rows[k].rd);
      end
      wr(10'h0c5, 8'hff, rsp);
      wr(10'h0d5, 8'h3c, rsp);
      wr(10'h0d0, 8'hff, rsp);
      st();
      check("oe5", o_port5_oe, 8'hff);
      check("out5", o_port5_out, 8'h3c);
      rchk(10'h0d5, 8'h3c);
      rchk(10'h0d0, 8'h03);
      wr(10'h1d5, 8'h01, rsp);
      wr(10'h2d5, 8'h04, rsp);
      st();
      check("out5 bits", o_port5_out, 8'h39);
      wr(10'h0c5, 8'h00, rsp);
      wr(10'h0e5, 8'hf0, rsp);
      e5_en <= 8'hff;
      e5_val <= 8'h5a;
      st();
      check("oe5 in", o_port5_oe, 8'h00);
      check("pu5", o_port5_pullup, 8'hf0);
      rchk(10'h0d5, 8'h5a);
      wr(10'h061, 8'h00, rsp);
      wr(10'h0e1, 8'hff, rsp);
      e1_en <= 8'h20;
      i_ext_reset_sel <= 1'h1;
      st();
      check("pu1", o_port1_pullup, 8'hdf);
      wr(10'h061, 8'hff, rsp);
      st();
      check("pu1 out", o_port1_pullup, 8'h00);
      check("oe1", o_port1_oe, 8'hdf);
      rchk(10'h0d1, 8'h20);
      i_ext_reset_sel <= 1'h0;
      wr(10'h0e9, 8'h01, rsp);
      st();
      check("od low", {o_port1_oe[0], o_port1_out[0]}, 2'h2);
      wr(10'h1d1, 8'h01, rsp);
      st();
      check("od high", {o_port1_oe[0], o_port1_out[0]}, 2'h1);
      rchk(10'h0d1, 8'h01);
      wr(10'h0e9, 8'h00, rsp);
      st();
      check("od off", {o_port1_oe[0], o_port1_out[0]}, 2'h3);
      i_rst <= 1'h1;
      repeat (4) @(posedge i_clk);
      i_rst <= 1'h0;
      check("oe1 rst", o_port1_oe, 8'h00);
      rchk(10'h061, 8'h20);
      rchk(10'h0c5, 8'h00);
      report_and_stop();
   end
endmodule
